// [design/ecc_dpram_defs.svh]
`ifndef ECC_DPRAM_DEFS_SVH
`define ECC_DPRAM_DEFS_SVH

// Datapath geometry.
`define RAW_W           8
`define CODE_W          13
`define ADDR_W          4
`define DEPTH           16

// Data bits covered by each Hamming check bit (codeword bits 8..11).
`define CHK_MASK_0      8'h5b
`define CHK_MASK_1      8'h6d
`define CHK_MASK_2      8'h8e
`define CHK_MASK_3      8'hf0
`define SYN_LAST_VALID  4'hc

// Register map on the APB slave.
`define APB_ADDR_W      8
`define OFF_CTRL        8'h00
`define OFF_STATUS      8'h04
`define CTRL_INJECT_BIT 0
`define CTRL_RESET      1'b0
`define STATUS_RESET    6'h00
`define STATUS_A_LSB    0
`define STATUS_B_LSB    3

`endif

// [design/ecc_dpram_pkg.sv]
`include "ecc_dpram_defs.svh"

package ecc_dpram_pkg;

    typedef struct packed {
        logic [`ADDR_W-1:0] addr;
        logic [`RAW_W-1:0]  data;
        logic               wr;
        logic               rd;
    } port_req_t;

    typedef struct packed {
        logic [`RAW_W-1:0] data;
        logic              corrected;
        logic              detected;
        logic              fatal;
    } result_t;

    typedef struct packed {
        logic [`ADDR_W-1:0] addr;
        logic [`CODE_W-1:0] code;
        logic               wr;
        logic               rd;
    } coded_req_t;

    typedef struct packed {
        coded_req_t                          enc_a;
        coded_req_t                          enc_b;
        logic                                inject;
        coded_req_t                          ram_a;
        coded_req_t                          ram_b;
        logic [`CODE_W-1:0]                  q_a;
        logic [`CODE_W-1:0]                  q_b;
        logic                                q_rd_a;
        logic                                q_rd_b;
        logic [`DEPTH-1:0][`CODE_W-1:0]      mem;
        result_t                             out_a;
        result_t                             out_b;
        logic                                valid_a;
        logic                                valid_b;
    } datapath_t;

    typedef struct packed {
        logic        inject;
        logic [5:0]  status;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } ctrl_state_t;

endpackage

// [design/ecc_dpram.sv]
// Behaviour
// - Each port encodes 8-bit write data into a 13-bit codeword and stores it.
// - Each write port has its own encoder in front of it.
// - Each read output has its own decoder before data leaves the block.
// - Decoders report no error, corrected single-bit error, or fatal multi-bit error.
// - While injection is on, port A codeword LSB is inverted before storing.
// - Encoder and decoder each add exactly one registered cycle.
// - Encoder and decoder registers have no clear and no enable.
// - Storage is true dual-port: both ports read or write any word.
// - The memory holds 16 words with a 4-bit address per port.
// - Array write and read data are 13 bits wide on both ports.
// - Both ports and all registers share one clock.
// - RAM registers write-side inputs and read outputs, two cycles read latency.
// - A read hitting the other port's write returns the old contents.
// - Port A read during its own write returns the new codeword.
// - Port B read during its own write returns the old codeword.
// - The RAM core reads every cycle at the presented address.
// - Memory is not preloaded; words are undefined until written.
// - Decoded data and status appear four cycles after the read is issued.
// - The port A injection control is active high and registered first.
// - Address and enables bypass the encoder through a matching stage.
// - Correction affects outputs only; the stored word stays corrupted.
`timescale 1ns/1ps
`include "ecc_dpram_defs.svh"

module ecc_dpram
    import ecc_dpram_pkg::*;
(
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [`APB_ADDR_W-1:0]  paddr,
    input  wire logic [31:0]             pwdata,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr,
    input  wire port_req_t               req_a,
    input  wire port_req_t               req_b,
    input  wire logic                    inject_lsb_error_a,
    output logic      [`RAW_W-1:0]       decoded_read_first,
    output logic                         corrected_flag_first,
    output logic                         detected_flag_first,
    output logic                         uncorrectable_flag_first,
    output logic                         read_valid_first,
    output logic      [`RAW_W-1:0]       decoded_read_second,
    output logic                         corrected_flag_second,
    output logic                         detected_flag_second,
    output logic                         uncorrectable_flag_second,
    output logic                         read_valid_second
);

    // Parity over the data bits that one check bit covers.
    function automatic logic check_bit(input logic [`RAW_W-1:0] d,
                                       input logic [`RAW_W-1:0] mask);
        return ^(d & mask);
    endfunction

    function automatic logic [`CODE_W-1:0] encode(input logic [`RAW_W-1:0] d);
        logic [`CODE_W-2:0] c;
        c[`RAW_W-1:0] = d;
        c[8]          = check_bit(d, `CHK_MASK_0);
        c[9]          = check_bit(d, `CHK_MASK_1);
        c[10]         = check_bit(d, `CHK_MASK_2);
        c[11]         = check_bit(d, `CHK_MASK_3);
        // The overall parity on top is what tells one flipped bit from two.
        return {^c, c};
    endfunction

    function automatic logic [3:0] syndrome(input logic [`CODE_W-1:0] c);
        logic [3:0] syn;
        syn[0] = check_bit(c[`RAW_W-1:0], `CHK_MASK_0) ^ c[8];
        syn[1] = check_bit(c[`RAW_W-1:0], `CHK_MASK_1) ^ c[9];
        syn[2] = check_bit(c[`RAW_W-1:0], `CHK_MASK_2) ^ c[10];
        syn[3] = check_bit(c[`RAW_W-1:0], `CHK_MASK_3) ^ c[11];
        return syn;
    endfunction

    // Check-bit and parity positions carry no data, so they need no repair
    // on the way out.
    function automatic logic [`RAW_W-1:0] flip_mask(input logic [3:0] syn);
        logic [`RAW_W-1:0] flip;
        case (syn)
            4'h0:    flip = 8'h00;
            4'h1:    flip = 8'h00;
            4'h2:    flip = 8'h00;
            4'h3:    flip = 8'h01;
            4'h4:    flip = 8'h00;
            4'h5:    flip = 8'h02;
            4'h6:    flip = 8'h04;
            4'h7:    flip = 8'h08;
            4'h8:    flip = 8'h00;
            4'h9:    flip = 8'h10;
            4'ha:    flip = 8'h20;
            4'hb:    flip = 8'h40;
            4'hc:    flip = 8'h80;
            default: flip = 8'h00;
        endcase
        return flip;
    endfunction

    function automatic result_t decode(input logic [`CODE_W-1:0] c);
        logic [3:0] syn;
        logic       odd;
        result_t    r;
        syn         = syndrome(c);
        odd         = ^c;
        r.data      = c[`RAW_W-1:0];
        r.corrected = 1'b0;
        r.fatal     = 1'b0;
        // An odd overall parity with a syndrome up to 4'hc means one flipped bit; an even one with a
        // nonzero syndrome can only be two or more.
        if (odd && syn <= `SYN_LAST_VALID)
        begin
            r.data      = c[`RAW_W-1:0] ^ flip_mask(syn);
            r.corrected = 1'b1;
        end
        else if (odd || syn != 4'h0)
        begin
            r.fatal = 1'b1;
        end
        r.detected = r.corrected | r.fatal;
        return r;
    endfunction

    // Address and enables skip the encoder but take the same register, so
    // they meet their codeword at the RAM.
    function automatic coded_req_t encode_req(input port_req_t q);
        coded_req_t e;
        e.addr = q.addr;
        e.code = encode(q.data);
        e.wr   = q.wr;
        e.rd   = q.rd;
        return e;
    endfunction

    function automatic logic [`CODE_W-1:0] read_port(input coded_req_t         p,
                                                     input logic [`CODE_W-1:0] stored,
                                                     input logic               new_data);
        logic [`CODE_W-1:0] q;
        q = stored;
        if (new_data && p.wr)
        begin
            q = p.code;
        end
        return q;
    endfunction

    // The stored word is only ever replaced whole, never repaired.
    function automatic logic [`DEPTH-1:0][`CODE_W-1:0] store(
        input logic [`DEPTH-1:0][`CODE_W-1:0] m,
        input coded_req_t                     p);
        logic [`DEPTH-1:0][`CODE_W-1:0] n;
        n = m;
        if (p.wr)
        begin
            n[p.addr] = p.code;
        end
        return n;
    endfunction

    function automatic logic [2:0] status_of(input result_t r);
        return {r.fatal, r.detected, r.corrected};
    endfunction

    // A status field follows the last read that carried a valid strobe.
    function automatic logic [5:0] update_status(input logic [5:0] st,
                                                 input logic       va,
                                                 input result_t    ra,
                                                 input logic       vb,
                                                 input result_t    rb);
        logic [5:0] n;
        n = st;
        if (va)
        begin
            n[`STATUS_A_LSB +: 3] = status_of(ra);
        end
        if (vb)
        begin
            n[`STATUS_B_LSB +: 3] = status_of(rb);
        end
        return n;
    endfunction

    function automatic logic is_mapped(input logic [`APB_ADDR_W-1:0] a);
        logic hit;
        case (a)
            `OFF_CTRL:   hit = 1'b1;
            `OFF_STATUS: hit = 1'b1;
            default:     hit = 1'b0;
        endcase
        return hit;
    endfunction

    // Unmapped offsets read as zero; the error response tells software why.
    function automatic logic [31:0] reg_read(input logic [`APB_ADDR_W-1:0] a,
                                             input logic                   inj,
                                             input logic [5:0]             st);
        logic [31:0] v;
        v = 32'h0000_0000;
        case (a)
            `OFF_CTRL:
            begin
                v[`CTRL_INJECT_BIT] = inj;
            end
            `OFF_STATUS:
            begin
                v[5:0] = st;
            end
            default:
            begin
                v = 32'h0000_0000;
            end
        endcase
        return v;
    endfunction

    // Status is read-only and unmapped offsets are ignored.
    function automatic logic reg_write(input logic                   inj,
                                       input logic [`APB_ADDR_W-1:0] a,
                                       input logic [31:0]            wdata);
        logic v;
        v = inj;
        case (a)
            `OFF_CTRL:
            begin
                v = wdata[`CTRL_INJECT_BIT];
            end
            default:
            begin
                v = inj;
            end
        endcase
        return v;
    endfunction

    datapath_t   d;
    datapath_t   next_d;
    ctrl_state_t s;
    ctrl_state_t next_s;
    logic        access;
    logic        setup;
    logic        mapped;

    always_comb
    begin
        next_d = d;
        // Encoder stage; address and enables take a matching register.
        next_d.enc_a  = encode_req(req_a);
        next_d.enc_b  = encode_req(req_b);
        next_d.inject = inject_lsb_error_a;

        // RAM input registers.
        next_d.ram_a.addr    = d.enc_a.addr;
        next_d.ram_a.code    = d.enc_a.code;
        next_d.ram_a.code[0] = d.enc_a.code[0] ^ (d.inject | s.inject);
        next_d.ram_a.wr      = d.enc_a.wr;
        next_d.ram_a.rd      = d.enc_a.rd;
        next_d.ram_b.addr    = d.enc_b.addr;
        next_d.ram_b.code    = d.enc_b.code;
        next_d.ram_b.wr      = d.enc_b.wr;
        next_d.ram_b.rd      = d.enc_b.rd;

        // Reads happen every cycle; the read strobe only travels along to
        // mark valid output, since the core itself has no read enable.
        next_d.q_a    = read_port(d.ram_a, d.mem[d.ram_a.addr], 1'b1);
        next_d.q_b    = read_port(d.ram_b, d.mem[d.ram_b.addr], 1'b0);
        next_d.q_rd_a = d.ram_a.rd;
        next_d.q_rd_b = d.ram_b.rd;

        // Port B is applied last, so a same-address double write keeps B.
        next_d.mem = store(d.mem, d.ram_a);
        next_d.mem = store(next_d.mem, d.ram_b);
        // Decoder stage; the stored word is never written back.
        next_d.out_a   = decode(d.q_a);
        next_d.out_b   = decode(d.q_b);
        next_d.valid_a = d.q_rd_a;
        next_d.valid_b = d.q_rd_b;
    end

    // No reset here: the memory starts undefined and the pipeline
    // registers carry neither a clear nor an enable.
    always_ff @(posedge pclk)
    begin
        d <= next_d;
    end

    assign setup  = psel & ~penable;
    assign access = psel & penable & s.pready;
    assign mapped = is_mapped(paddr);

    always_comb
    begin
        next_s         = s;
        next_s.pready  = setup;
        next_s.pslverr = 1'b0;
        next_s.prdata  = 32'h0000_0000;
        // Read data is fetched in the setup cycle, so the single access cycle
        // already carries it and no wait state is needed.
        if (setup)
        begin
            next_s.pslverr = ~mapped;
            if (!pwrite)
            begin
                next_s.prdata = reg_read(paddr, s.inject, s.status);
            end
        end
        if (access && pwrite)
        begin
            next_s.inject = reg_write(s.inject, paddr, pwdata);
        end
        next_s.status = update_status(s.status, d.valid_a, d.out_a, d.valid_b, d.out_b);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s.inject  <= `CTRL_RESET;
            s.status  <= `STATUS_RESET;
            s.prdata  <= 32'h0000_0000;
            s.pready  <= 1'b0;
            s.pslverr <= 1'b0;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign prdata                    = s.prdata;
    assign pready                    = s.pready;
    assign pslverr                   = s.pslverr;
    assign decoded_read_first        = d.out_a.data;
    assign corrected_flag_first      = d.out_a.corrected;
    assign detected_flag_first       = d.out_a.detected;
    assign uncorrectable_flag_first  = d.out_a.fatal;
    assign read_valid_first          = d.valid_a;
    assign decoded_read_second       = d.out_b.data;
    assign corrected_flag_second     = d.out_b.corrected;
    assign detected_flag_second      = d.out_b.detected;
    assign uncorrectable_flag_second = d.out_b.fatal;
    assign read_valid_second         = d.valid_b;

endmodule

// [tb/ecc_dpram_checker.sv]
`timescale 1ns/1ps
`include "ecc_dpram_defs.svh"
module ecc_dpram_checker
    import ecc_dpram_pkg::*;
(
    input wire logic                   pclk,
    input wire logic                   presetn,
    input wire logic                   psel,
    input wire logic                   penable,
    input wire logic [`APB_ADDR_W-1:0] paddr,
    input wire logic [31:0]            prdata,
    input wire logic                   pready,
    input wire logic                   pslverr,
    input wire port_req_t              req_a,
    input wire port_req_t              req_b,
    input wire logic                   inject_lsb_error_a,
    input wire logic [`RAW_W-1:0]      decoded_read_first,
    input wire logic                   corrected_flag_first,
    input wire logic                   detected_flag_first,
    input wire logic                   uncorrectable_flag_first,
    input wire logic                   read_valid_first,
    input wire logic                   read_valid_second
);
    // A same-address write from B replaces port A's stored word, since B is applied last, so those cycles are skipped.
    wire clash = req_b.wr && req_b.addr == req_a.addr;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_valid_a_delay: assert property (req_a.rd |-> ##4 read_valid_first)
        else $error("port A valid late");
    a_idle_b_quiet: assert property (!req_b.rd |-> ##4 !read_valid_second)
        else $error("port B valid spurious");
    a_new_data_a: assert property (req_a.wr && !clash
        |-> ##4 decoded_read_first == $past(req_a.data, 4))
        else $error("port A data wrong");
    a_inject_flags: assert property (req_a.wr && inject_lsb_error_a && !clash
        |-> ##4 corrected_flag_first && detected_flag_first && !uncorrectable_flag_first)
        else $error("injected error not corrected");
    a_corr_class: assert property (corrected_flag_first
        |-> detected_flag_first && !uncorrectable_flag_first)
        else $error("status classes overlap");
    a_ready_zero_wait: assert property (psel && !penable |=> pready)
        else $error("pready late");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready too long");
    a_unmapped_err: assert property (psel && !penable && paddr != `OFF_CTRL && paddr != `OFF_STATUS
        |=> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
endmodule

bind ecc_dpram ecc_dpram_checker chk (.pclk, .presetn, .psel, .penable, .paddr, .prdata, .pready,
    .pslverr, .req_a, .req_b, .inject_lsb_error_a, .decoded_read_first, .corrected_flag_first,
    .detected_flag_first, .uncorrectable_flag_first, .read_valid_first, .read_valid_second);

// [tb/user_logic.sv]
`timescale 1ns/1ps
module user_logic
    import ecc_dpram_pkg::*;
(
    input  wire logic pclk,
    output port_req_t req_a,
    output port_req_t req_b,
    output logic      inject_a
);
    initial
    begin
        req_a = '0;
        req_b = '0;
        inject_a = 1'b0;
    end
    task automatic op(input port_req_t a, input port_req_t b, input logic inj);
        if (a.wr && b.wr && a.addr == b.addr)
            b.wr = 1'b0;
        @(posedge pclk);
        req_a <= a;
        req_b <= b;
        inject_a <= inj;
        @(posedge pclk);
        // Stale data is inverted so a late sample in the design shows up as a wrong word.
        req_a <= '{a.addr, ~a.data, 1'b0, 1'b0};
        req_b <= '{b.addr, ~b.data, 1'b0, 1'b0};
        inject_a <= 1'b0;
    endtask
endmodule

// [tb/testbench.sv]
`timescale 1ns/1ps
module testbench
    import ecc_dpram_pkg::*;
;
    localparam port_req_t idle = '0;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdata;
    logic pready, pslverr, inject_a, cor_a, det_a, fat_a, val_a, cor_b, det_b, fat_b, val_b;
    logic [7:0] dec_a, dec_b;
    logic [4:0] k;
    port_req_t req_a, req_b;
    int err_count = 0;
    int compares = 0;
    wire [11:0] res_a = {val_a, cor_a, det_a, fat_a, dec_a};
    wire [11:0] res_b = {val_b, cor_b, det_b, fat_b, dec_b};
    always #5 pclk = ~pclk;
    user_logic usr (.pclk, .req_a, .req_b, .inject_a);
    ecc_dpram uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .req_a, .req_b, .inject_lsb_error_a(inject_a), .decoded_read_first(dec_a),
        .corrected_flag_first(cor_a), .detected_flag_first(det_a),
        .uncorrectable_flag_first(fat_a), .read_valid_first(val_a), .decoded_read_second(dec_b),
        .corrected_flag_second(cor_b), .detected_flag_second(det_b),
        .uncorrectable_flag_second(fat_b), .read_valid_second(val_b));
    function automatic port_req_t r(input logic [3:0] a, input logic [7:0] d, input logic w,
        input logic rd);
        return '{a, d, w, rd};
    endfunction
    function automatic logic [7:0] dat(input logic [3:0] a);
        return {a, ~a};
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20)
        begin
            @(posedge pclk);
            n++;
        end
        if (n == 20)
            err_count++;
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // The hand-over fixes three edges from the sampling edge to the result.
    task automatic run(input port_req_t a, input port_req_t b, input logic i);
        usr.op(a, b, i);
        repeat (3) @(posedge pclk);
        #1;
    endtask
    task automatic end_of_test;
        if (err_count == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial
    begin
        #100000;
        err_count++;
        end_of_test;
    end
    initial
    begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 8'h00, 32'h0);
        check(rdata, 32'h0);
        apb(1'b0, 8'h04, 32'h0);
        check(rdata, 32'h0);
        for (k = 0; k < 16; k++)
        begin
            run(r(k[3:0], dat(k[3:0]), 1'b1, 1'b1), idle, 1'b0);
            check(res_a, {4'h8, dat(k[3:0])});
        end
        for (k = 0; k < 16; k++)
        begin
            run(idle, r(k[3:0], 8'h00, 1'b0, 1'b1), 1'b0);
            check(res_b, {4'h8, dat(k[3:0])});
        end
        run(idle, r(4'h2, 8'h66, 1'b1, 1'b1), 1'b0);
        check(res_b, {4'h8, dat(4'h2)});
        run(idle, r(4'h2, 8'h00, 1'b0, 1'b1), 1'b0);
        check(res_b, 12'h866);
        run(r(4'h3, 8'hcc, 1'b1, 1'b0), r(4'h3, 8'h00, 1'b0, 1'b1), 1'b0);
        check(res_b, {4'h8, dat(4'h3)});
        run(idle, r(4'h3, 8'h00, 1'b0, 1'b1), 1'b0);
        check(res_b, 12'h8cc);
        run(r(4'h5, 8'hff, 1'b1, 1'b1), idle, 1'b1);
        check(res_a, 12'heff);
        run(r(4'h5, 8'h00, 1'b0, 1'b1), idle, 1'b0);
        check(res_a, 12'heff);
        apb(1'b0, 8'h04, 32'h0);
        check(rdata, 32'h3);
        apb(1'b1, 8'h00, 32'h1);
        apb(1'b0, 8'h00, 32'h0);
        check(rdata, 32'h1);
        run(r(4'h6, 8'h81, 1'b1, 1'b1), idle, 1'b0);
        check(res_a, 12'he81);
        apb(1'b1, 8'h00, 32'h0);
        run(r(4'h6, 8'h81, 1'b1, 1'b1), idle, 1'b0);
        check(res_a, 12'h881);
        apb(1'b1, 8'h04, 32'hff);
        apb(1'b0, 8'h04, 32'h0);
        check(rdata, 32'h0);
        apb(1'b0, 8'h10, 32'h0);
        check({31'h0, err}, 32'h1);
        check(rdata, 32'h0);
        end_of_test;
    end
endmodule
